// ### hw/umaf_pkg.sv
// Constants, types and register map of the multiprocessor address filter
package umaf_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] UMAF_IDX_CTRL               = 8'h00;
   localparam logic [7:0] UMAF_IDX_STAT               = 8'h01;
   localparam logic [7:0] UMAF_IDX_RXBUF              = 8'h02;
   localparam logic [7:0] UMAF_IDX_EVT                = 8'h03;
   localparam logic [7:0] UMAF_IDX_EVT_MASK           = 8'h04;
   localparam logic [7:0] UMAF_IDX_SLAVE_ADDRESS      = 8'ha9;
   localparam logic [7:0] UMAF_IDX_SLAVE_ADDRESS_MASK = 8'hb9;

   // Index field inside a byte address
   localparam int UMAF_IDX_LSB = 2;
   localparam int UMAF_IDX_MSB = 9;

   // Control register fields
   localparam int UMAF_CTRL_MODE_LSB = 0;
   localparam int UMAF_CTRL_MODE_MSB = 1;
   localparam int UMAF_CTRL_AFE_BIT  = 2;
   localparam int UMAF_CTRL_TNB_BIT  = 3;
   localparam logic [7:0] UMAF_CTRL_WMASK = 8'h0f;

   // Receive status register fields
   localparam int UMAF_STAT_RCF_BIT = 0;
   localparam int UMAF_STAT_RNB_BIT = 1;

   // Event status and mask fields
   localparam int UMAF_EVT_W        = 3;
   localparam int UMAF_EVT_ACC_BIT  = 0;
   localparam int UMAF_EVT_LOST_BIT = 1;
   localparam int UMAF_EVT_FILT_BIT = 2;

   // Reset values
   localparam logic [7:0] UMAF_RST_CTRL               = 8'h00;
   localparam logic [7:0] UMAF_RST_SLAVE_ADDRESS      = 8'h00;
   localparam logic [7:0] UMAF_RST_SLAVE_ADDRESS_MASK = 8'h00;
   localparam logic [7:0] UMAF_RST_EVT_MASK           = 8'h00;
   localparam logic [7:0] UMAF_RST_RXBUF              = 8'h00;

   // AXI responses
   localparam logic [1:0] UMAF_RESP_OKAY   = 2'b00;
   localparam logic [1:0] UMAF_RESP_SLVERR = 2'b10;

   // Serial port modes
   typedef enum logic [1:0] {
      UMAF_MODE_SYNC     = 2'b00,
      UMAF_MODE_ASYNC10  = 2'b01,
      UMAF_MODE_ASYNC11F = 2'b10,
      UMAF_MODE_ASYNC11V = 2'b11
   } umaf_mode_e;

   // One finished frame from the receive shifter
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       ninth;
   } umaf_rx_s;

endpackage : umaf_pkg

// ### hw/umaf_match.sv
// Masked byte comparator used for given and broadcast addresses
`timescale 1ns/1ps
module umaf_match #(
   parameter int W = 8
) (
   // Compare operands
   input  wire logic [W-1:0] byte_in,
   input  wire logic [W-1:0] ref_addr,
   input  wire logic [W-1:0] care_mask,
   // Result
   output wire logic         hit
);

   // Zero mask bits are don't-care positions
   assign hit = ((byte_in ^ ref_addr) & care_mask) == '0;

endmodule : umaf_match

// ### hw/umaf_top.sv
// Multiprocessor address filter with AXI4-Lite register slave
//
// Operation
// - Filter works on the ninth frame bit in both 9-bit async modes.
// - Ninth bit one marks an address byte, zero marks a data byte.
// - With filter on, flag is set only on given or broadcast match.
// - With filter off, flag is set for every complete frame.
// - In 10-bit mode stop bit acts as ninth bit; needs one and match.
// - Given address is slave address, compared where mask bit is one.
// - Broadcast address is address OR mask; its zeros are don't-care.
// - Address and mask registers sit at indices a9 and b9.
// - Both address registers reset to zero, so everything matches.
// - Ninth bit received is stored; transmit ninth bit is driven out.
// - Load only when flag clear and filter off or ninth bit one.
`timescale 1ns/1ps
module umaf_top
   import umaf_pkg::*;
#(
   parameter int AW = 12
) (
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // AXI4-Lite write address
   input  wire logic [AW-1:0] awaddr,
   input  wire logic          awvalid,
   output wire logic          awready,
   // AXI4-Lite write data
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output wire logic          wready,
   // AXI4-Lite write response
   output wire logic [1:0]    bresp,
   output wire logic          bvalid,
   input  wire logic          bready,
   // AXI4-Lite read address
   input  wire logic [AW-1:0] araddr,
   input  wire logic          arvalid,
   output wire logic          arready,
   // AXI4-Lite read data
   output wire logic [31:0]   rdata,
   output wire logic [1:0]    rresp,
   output wire logic          rvalid,
   input  wire logic          rready,
   // Frame from the receive shifter
   input  wire umaf_rx_s      rx_frame,
   // Serial port side outputs
   output wire logic [1:0]    serial_mode,
   output wire logic          transmit_ninth_bit,
   output wire logic          receive_complete_flag,
   output wire logic          received_ninth_bit,
   output wire logic [7:0]    rx_buffer,
   // Interrupt
   output wire logic          irq
);

   // Register state
   logic [7:0]            ctrl_q;
   logic [7:0]            slave_address_q;
   logic [7:0]            slave_address_mask_q;
   logic [7:0]            rx_buf_q;
   logic [7:0]            evt_mask_q;
   logic                  rcf_q;
   logic                  rnb_q;
   logic [UMAF_EVT_W-1:0] evt_q;
   logic [UMAF_EVT_W-1:0] evt_d;
   // Bus state
   logic                  aw_got_q;
   logic                  w_got_q;
   logic [AW-1:0]         awaddr_q;
   logic [7:0]            wbyte_q;
   logic                  wlane0_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   logic                  rvalid_q;
   logic [31:0]           rdata_q;
   logic [1:0]            rresp_q;
   // Control fields
   umaf_mode_e            mode;
   logic                  filter_en;
   logic                  filter_on;
   // Write channel handshakes
   wire aw_fire = awvalid && awready;
   wire w_fire  = wvalid && wready;
   wire wr_fire = aw_got_q && w_got_q && !bvalid_q;
   assign awready = !aw_got_q && !bvalid_q;
   assign wready  = !w_got_q && !bvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   // Write address decode on the held address
   wire [7:0] wr_idx = awaddr_q[UMAF_IDX_MSB:UMAF_IDX_LSB];
   wire       wr_hi0 = awaddr_q[AW-1:UMAF_IDX_MSB+1] == '0;
   wire       wr_ctl = wr_hi0 && (wr_idx == UMAF_IDX_CTRL);
   wire       wr_sta = wr_hi0 && (wr_idx == UMAF_IDX_STAT);
   wire       wr_rxb = wr_hi0 && (wr_idx == UMAF_IDX_RXBUF);
   wire       wr_evt = wr_hi0 && (wr_idx == UMAF_IDX_EVT);
   wire       wr_emk = wr_hi0 && (wr_idx == UMAF_IDX_EVT_MASK);
   wire       wr_sad = wr_hi0 && (wr_idx == UMAF_IDX_SLAVE_ADDRESS);
   wire       wr_smk = wr_hi0 && (wr_idx == UMAF_IDX_SLAVE_ADDRESS_MASK);
   wire       wr_map = wr_ctl || wr_sta || wr_rxb || wr_evt
                       || wr_emk || wr_sad || wr_smk;
   // Byte lane 0 carries all register bits
   wire       wr_go  = wr_fire && wlane0_q;
   wire       rcf_clr = wr_go && wr_sta && wbyte_q[UMAF_STAT_RCF_BIT];

   // Read channel handshake and decode
   wire       ar_fire = arvalid && arready;
   wire [7:0] rd_idx  = araddr[UMAF_IDX_MSB:UMAF_IDX_LSB];
   wire       rd_hi0  = araddr[AW-1:UMAF_IDX_MSB+1] == '0;
   wire       rd_ctl  = rd_hi0 && (rd_idx == UMAF_IDX_CTRL);
   wire       rd_sta  = rd_hi0 && (rd_idx == UMAF_IDX_STAT);
   wire       rd_rxb  = rd_hi0 && (rd_idx == UMAF_IDX_RXBUF);
   wire       rd_evt  = rd_hi0 && (rd_idx == UMAF_IDX_EVT);
   wire       rd_emk  = rd_hi0 && (rd_idx == UMAF_IDX_EVT_MASK);
   wire       rd_sad  = rd_hi0 && (rd_idx == UMAF_IDX_SLAVE_ADDRESS);
   wire       rd_smk  = rd_hi0 && (rd_idx == UMAF_IDX_SLAVE_ADDRESS_MASK);
   wire       rd_map  = rd_ctl || rd_sta || rd_rxb || rd_evt
                        || rd_emk || rd_sad || rd_smk;
   wire       evt_clr = ar_fire && rd_evt;
   assign arready = !rvalid_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   // Status byte as software sees it
   wire [7:0] stat_byte = 8'(({7'h00, rnb_q} << UMAF_STAT_RNB_BIT)
                            | ({7'h00, rcf_q} << UMAF_STAT_RCF_BIT));

   // Read data selection; unmapped reads return zero
   wire [7:0] rd_byte = rd_ctl ? ctrl_q :
                        rd_sta ? stat_byte :
                        rd_rxb ? rx_buf_q :
                        rd_evt ? {{(8-UMAF_EVT_W){1'b0}}, evt_q} :
                        rd_emk ? evt_mask_q :
                        rd_sad ? slave_address_q :
                        rd_smk ? slave_address_mask_q :
                        8'h00;

   // Control field extraction
   assign mode      = umaf_mode_e'(ctrl_q[UMAF_CTRL_MODE_MSB:UMAF_CTRL_MODE_LSB]);
   assign filter_en = ctrl_q[UMAF_CTRL_AFE_BIT];

   // filter in async modes
   // Mode 0 has no ninth bit, so the filter bit has no effect there
   assign filter_on = filter_en && (mode != UMAF_MODE_SYNC);

   // Address comparators
   logic given_hit;
   logic bcast_hit;
   logic addr_match;
   logic [7:0] bcast_care;

   assign bcast_care = slave_address_q | slave_address_mask_q;

   umaf_match #(
      .W         (8)
   ) u_given (
      .byte_in   (rx_frame.data),
      .ref_addr  (slave_address_q),
      .care_mask (slave_address_mask_q),
      .hit       (given_hit)
   );

   umaf_match #(
      .W         (8)
   ) u_bcast (
      .byte_in   (rx_frame.data),
      .ref_addr  (8'hff),
      .care_mask (bcast_care),
      .hit       (bcast_hit)
   );

   assign addr_match = given_hit || bcast_hit;

   // Frame qualification
   logic frame_ok;
   logic rx_accept;
   logic rx_lost;
   logic rx_filtered;

   // stop bit stands in mode 1
   assign frame_ok = !filter_on || (rx_frame.ninth && addr_match);

   assign rx_accept   = rx_frame.valid && !rcf_q && frame_ok;
   assign rx_lost     = rx_frame.valid && rcf_q && frame_ok;
   assign rx_filtered = rx_frame.valid && !frame_ok;

   // New events this cycle
   wire [UMAF_EVT_W-1:0] evt_new =
      UMAF_EVT_W'(({2'b00, rx_accept}   << UMAF_EVT_ACC_BIT)
                | ({2'b00, rx_lost}     << UMAF_EVT_LOST_BIT)
                | ({2'b00, rx_filtered} << UMAF_EVT_FILT_BIT));

   // Read clears the sticky bits, a new event in that cycle survives
   assign evt_d = (evt_clr ? '0 : evt_q) | evt_new;

   // Outputs to the serial port
   assign serial_mode           = ctrl_q[UMAF_CTRL_MODE_MSB:UMAF_CTRL_MODE_LSB];
   assign receive_complete_flag = rcf_q;
   assign received_ninth_bit    = rnb_q;
   assign rx_buffer             = rx_buf_q;

   assign transmit_ninth_bit    = ctrl_q[UMAF_CTRL_TNB_BIT];

   // One level interrupt from unmasked sticky events
   assign irq = |(evt_q & evt_mask_q[UMAF_EVT_W-1:0]);

   // Write address capture; address held until the response is issued
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_q <= 1'b0;
         awaddr_q <= '0;
      end
      else if (aw_fire)
      begin
         aw_got_q <= 1'b1;
         awaddr_q <= awaddr;
      end
      else if (wr_fire)
         aw_got_q <= 1'b0;
   end

   // Write data capture, independent of the address; upper lanes ignored
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_got_q  <= 1'b0;
         wbyte_q  <= 8'h00;
         wlane0_q <= 1'b0;
      end
      else if (w_fire)
      begin
         w_got_q  <= 1'b1;
         wbyte_q  <= wdata[7:0];
         wlane0_q <= wstrb[0];
      end
      else if (wr_fire)
         w_got_q <= 1'b0;
   end

   // Write response, one per completed address and data pair
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= UMAF_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_map ? UMAF_RESP_OKAY : UMAF_RESP_SLVERR;
      end
      else if (bready)
         bvalid_q <= 1'b0;
   end

   // Read response; a new read is refused until this one is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= UMAF_RESP_OKAY;
      end
      else if (ar_fire)
      begin
         rvalid_q <= 1'b1;
         rdata_q  <= {24'h00_0000, rd_byte};
         rresp_q  <= rd_map ? UMAF_RESP_OKAY : UMAF_RESP_SLVERR;
      end
      else if (rready)
         rvalid_q <= 1'b0;
   end

   // Control and interrupt mask; reserved control bits stay zero
   // software drops the filter bit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q     <= UMAF_RST_CTRL;
         evt_mask_q <= UMAF_RST_EVT_MASK;
      end
      else
      begin
         if (wr_go && wr_ctl)
            ctrl_q <= wbyte_q & UMAF_CTRL_WMASK;
         if (wr_go && wr_emk)
            evt_mask_q <= wbyte_q;
      end
   end

   // address registers at a9 and b9
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         slave_address_q      <= UMAF_RST_SLAVE_ADDRESS;
         slave_address_mask_q <= UMAF_RST_SLAVE_ADDRESS_MASK;
      end
      else
      begin
         if (wr_go && wr_sad)
            slave_address_q <= wbyte_q;
         if (wr_go && wr_smk)
            slave_address_mask_q <= wbyte_q;
      end
   end

   // flag set on accepted frame
   // Set beats a software clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rcf_q <= 1'b0;
      else if (rx_accept)
         rcf_q <= 1'b1;
      else if (rcf_clr)
         rcf_q <= 1'b0;
   end

   // store received ninth bit
   // Mode 0 frames carry no ninth bit, so the old value is kept
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rnb_q    <= 1'b0;
         rx_buf_q <= UMAF_RST_RXBUF;
      end
      else if (rx_accept)
      begin
         rx_buf_q <= rx_frame.data;
         if (mode != UMAF_MODE_SYNC)
            rnb_q <= rx_frame.ninth;
      end
   end

   // Sticky event status
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         evt_q <= '0;
      else
         evt_q <= evt_d;
   end

endmodule : umaf_top

// ### dv/umaf_checker.sv
// Port-level concurrent checks for the address filter
`timescale 1ns/1ps
module umaf_checker
   import umaf_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        awready,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic [31:0] rdata,
   // Receive path
   input wire umaf_rx_s    rx_frame,
   input wire logic [1:0]  serial_mode,
   input wire logic        receive_complete_flag,
   input wire logic        received_ninth_bit,
   input wire logic [7:0]  rx_buffer,
   input wire logic        irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_flag_from_frame:
      assert property ($rose(receive_complete_flag) |-> $past(rx_frame.valid))
      else $error("flag rose without a frame");
   a_lost_keeps_buf:
      assert property (rx_frame.valid && receive_complete_flag |=> $stable(rx_buffer))
      else $error("buffer changed on a lost frame");
   a_buf_takes_byte:
      assert property ($rose(receive_complete_flag) |-> rx_buffer == $past(rx_frame.data))
      else $error("buffer does not hold the taken byte");
   a_idle_keeps_buf:
      assert property (!rx_frame.valid |=> $stable(rx_buffer))
      else $error("buffer changed without a frame");
   a_ninth_stored:
      assert property ($rose(receive_complete_flag) && serial_mode != UMAF_MODE_SYNC
                       |-> received_ninth_bit == $past(rx_frame.ninth))
      else $error("ninth bit not stored");
   a_write_refused:
      assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   a_read_answer:
      assert property (arvalid && arready |=> rvalid && !arready && rdata[31:8] == 24'h0)
      else $error("read answer late or malformed");
   a_irq_cause:
      assert property ($rose(irq) |-> $past(rx_frame.valid) || $rose(bvalid))
      else $error("interrupt rose without a cause");

   // Main scenarios reached
   c_taken: cover property ($rose(receive_complete_flag));
   c_lost: cover property (rx_frame.valid && receive_complete_flag);
   c_irq: cover property ($rose(irq));
endmodule : umaf_checker

// ### dv/umaf_frame_src.sv
// Far station on the shared line, handing finished frames in
`timescale 1ns/1ps
module umaf_frame_src
   import umaf_pkg::*;
(
   // Clock
   input  wire logic aclk,
   // Frame towards the block
   output umaf_rx_s  frame
);
   initial frame = '0;

   task automatic send(input logic [7:0] d, input logic n);
      @(posedge aclk);
      frame <= '{valid: 1'b1, data: d, ninth: n};
      @(posedge aclk);
      // Idle lines show the inverse, so stale bytes cannot pass
      frame <= '{valid: 1'b0, data: ~d, ninth: ~n};
   endtask : send
endmodule : umaf_frame_src

// ### dv/test_uart_multiproc_address_filter.sv
// Self-checking bench for the multiprocessor address filter
`timescale 1ns/1ps
module test_uart_multiproc_address_filter import umaf_pkg::*;;
   localparam logic [1:0] OK = UMAF_RESP_OKAY;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h1;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   wire logic   awready, wready, bvalid, arready, rvalid, irq;
   wire logic   receive_complete_flag, received_ninth_bit, transmit_ninth_bit;
   wire logic [1:0]  bresp, rresp, serial_mode;
   wire logic [31:0] rdata;
   wire logic [7:0]  rx_buffer;
   wire umaf_rx_s    rx_frame;
   logic [33:0] exp_q [$];
   logic [7:0]  d1;
   logic [7:0]  ab [9] = '{8'ha0, 8'ha1, 8'ha5, 8'ha4, 8'hff, 8'hfe, 8'ha3, 8'hb0, 8'h7f};
   int          n_errors = 0, n_checks = 0, cyc = 0;
   int          seed = 32'h163c56c8;

   umaf_frame_src src (.aclk(aclk), .frame(rx_frame));
   umaf_top #(.AW(12)) uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .rx_frame(rx_frame), .serial_mode(serial_mode),
      .transmit_ninth_bit(transmit_ninth_bit), .receive_complete_flag(receive_complete_flag),
      .received_ninth_bit(received_ninth_bit), .rx_buffer(rx_buffer), .irq(irq));

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_of_test;
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test

   function automatic logic [11:0] ba(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : ba

   // Write one register; each channel released once taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      @(posedge aclk);
      awaddr <= ba(idx);
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      while (!tb)
      begin
         @(negedge aclk);
         ta = awready;
         tw = wready;
         tb = bvalid;
         if (tb)
            chk({32'h0, bresp}, {32'h0, er});
         @(posedge aclk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask : wr

   // Read one register; the expected answer goes to the queue
   task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic ta, tr;
      exp_q.push_back({er, 24'h0, d});
      @(posedge aclk);
      araddr <= ba(idx);
      arvalid <= 1'b1;
      rready <= 1'b1;
      tr = 1'b0;
      while (!tr)
      begin
         @(negedge aclk);
         ta = arready;
         tr = rvalid;
         @(posedge aclk);
         if (ta)
            arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask : rd

   // Send a frame, check acceptance, clear the flag after a hit
   task automatic fr(input logic [7:0] d, input logic n, input logic hit);
      src.send(d, n);
      @(negedge aclk);
      chk({33'h0, receive_complete_flag}, {33'h0, hit});
      if (hit)
      begin
         chk({25'h0, received_ninth_bit, rx_buffer}, {25'h0, n, d});
         wr(UMAF_IDX_STAT, 8'h01, OK);
      end
   endtask : fr

   // Read answers compared against the oldest note
   always @(negedge aclk)
      if (rvalid === 1'b1 && rready === 1'b1)
         chk({rresp, rdata}, exp_q.pop_front());

   // Clock and hang guard
   initial
      forever #10 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         n_errors++;
         end_of_test;
      end
   end

   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(UMAF_IDX_SLAVE_ADDRESS, 8'h00, OK);
      rd(UMAF_IDX_SLAVE_ADDRESS_MASK, 8'h00, OK);
      rd(8'h40, 8'h00, UMAF_RESP_SLVERR);
      wr(8'h40, 8'h5a, UMAF_RESP_SLVERR);
      $display("T1 reset values done");
      wr(UMAF_IDX_CTRL, 8'h06, OK);
      fr(8'($random(seed)), 1'b1, 1'b1);
      fr(8'h33, 1'b0, 1'b0);
      $display("T2 open match done");
      wr(UMAF_IDX_SLAVE_ADDRESS, 8'ha4, OK);
      wr(UMAF_IDX_SLAVE_ADDRESS_MASK, 8'hfa, OK);
      rd(UMAF_IDX_SLAVE_ADDRESS_MASK, 8'hfa, OK);
      // A write without lane 0 is answered but changes nothing
      wstrb <= 4'h0;
      wr(UMAF_IDX_SLAVE_ADDRESS, 8'h5a, OK);
      wstrb <= 4'h1;
      rd(UMAF_IDX_SLAVE_ADDRESS, 8'ha4, OK);
      for (int m = 2; m < 4; m++)
      begin
         wr(UMAF_IDX_CTRL, 8'(m) | 8'h04, OK);
         chk({32'h0, serial_mode}, 34'(m));
         for (int i = 0; i < 9; i++)
            fr(ab[i], 1'b1, i < 6);
      end
      wr(UMAF_IDX_CTRL, 8'h05, OK);
      fr(8'ha0, 1'b0, 1'b0);
      fr(8'ha3, 1'b1, 1'b0);
      fr(8'ha0, 1'b1, 1'b1);
      // Mode 0 ignores the filter and keeps the stored ninth bit
      wr(UMAF_IDX_CTRL, 8'h04, OK);
      chk({32'h0, serial_mode}, 34'h0);
      src.send(8'h33, 1'b0);
      @(negedge aclk);
      chk({24'h0, receive_complete_flag, received_ninth_bit, rx_buffer}, 34'h333);
      wr(UMAF_IDX_STAT, 8'h01, OK);
      $display("T3 address table done");
      rd(UMAF_IDX_EVT, 8'h05, OK);
      wr(UMAF_IDX_CTRL, 8'h0e, OK);
      chk({33'h0, transmit_ninth_bit}, 34'h1);
      fr(8'ha4, 1'b1, 1'b1);
      wr(UMAF_IDX_CTRL, 8'h0a, OK);
      d1 = 8'($random(seed));
      src.send(d1, 1'b0);
      src.send(~d1, 1'b0);
      rd(UMAF_IDX_RXBUF, d1, OK);
      rd(UMAF_IDX_STAT, 8'h01, OK);
      rd(UMAF_IDX_EVT, 8'h03, OK);
      rd(UMAF_IDX_EVT, 8'h00, OK);
      wr(UMAF_IDX_STAT, 8'h01, OK);
      $display("T4 data and lost frame done");
      wr(UMAF_IDX_EVT_MASK, 8'h01, OK);
      fr(d1, 1'b0, 1'b1);
      chk({33'h0, irq}, 34'h1);
      wr(UMAF_IDX_EVT_MASK, 8'h00, OK);
      chk({33'h0, irq}, 34'h0);
      wr(UMAF_IDX_EVT_MASK, 8'h01, OK);
      rd(UMAF_IDX_EVT, 8'h01, OK);
      @(negedge aclk);
      chk({33'h0, irq}, 34'h0);
      $display("T5 interrupt done");
      end_of_test;
   end
endmodule : test_uart_multiproc_address_filter

bind umaf_top umaf_checker u_chk (.aclk(aclk), .aresetn(aresetn), .awready(awready),
   .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rdata(rdata), .rx_frame(rx_frame), .serial_mode(serial_mode),
   .receive_complete_flag(receive_complete_flag), .received_ninth_bit(received_ninth_bit),
   .rx_buffer(rx_buffer), .irq(irq));
